/* File: xfer_swap_defines.svh */
// Offsets, field positions and constants of the block transfer and exchange unit
`ifndef XFER_SWAP_DEFINES_SVH
`define XFER_SWAP_DEFINES_SVH
`define ADR_BLOCK_CMD   8'h00
`define ADR_STATUS      8'h04
`define ADR_PSW         8'h08
`define ADR_CACHE_CTRL  8'h0c
`define ADR_SWAP_CMD    8'h10
`define ADR_REGFILE     8'h40
`define ADR_REGFILE_END 8'h7c
`define BC_LIST_LSB     0
`define BC_BASE_LSB     16
`define BC_LOAD_BIT     28
`define BC_PRE_BIT      29
`define BC_UP_BIT       30
`define BC_WB_BIT       31
`define SC_BASE_LSB     0
`define SC_SRC_LSB      4
`define SC_DST_LSB      8
`define SC_BYTE_BIT     12
`define ST_BUSY_BIT     0
`define ST_ADDR_EXC_BIT 1
`define ST_ABORT_BIT    2
`define ST_DONE_BIT     3
`define PSW_MODE_LSB    0
`define PSW_IRQ_LSB     2
`define PSW_FLAG_LSB    4
`define PSW_RESET       8'h03
`define CACHE_EN_RESET  1'b0
`define ILLEGAL_HI      31
`define ILLEGAL_LO      26
`define PC_AHEAD        26'h0000008
`define COUNTER_IDX     4'hf
`define WORD_BYTES      26'h0000004
`endif

/* File: xfer_swap_pkg.sv */
// Types of the block transfer and exchange unit
package xfer_swap_pkg;
  typedef enum logic [5:0] {
    ST_IDLE   = 6'b000001,
    ST_SETUP  = 6'b000010,
    ST_XFER   = 6'b000100,
    ST_FINISH = 6'b001000,
    ST_SWRD   = 6'b010000,
    ST_SWWR   = 6'b100000
  } state_t;
  typedef logic [3:0] reg_idx_t;
endpackage : xfer_swap_pkg

/* File: xfer_swap_unit.sv */
// Block load/store and atomic exchange engine with a Wishbone register port
`include "xfer_swap_defines.svh"
module xfer_swap_unit
  import xfer_swap_pkg::*;
#(
  parameter int NUM_REGS = 16
) (
  input  wire logic        MCLK,
  input  wire logic        SRST,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  output logic             MEM_REQ,
  output logic             MEM_WE,
  output logic      [31:0] MEM_ADDR,
  output logic      [31:0] MEM_WDATA,
  input  wire logic [31:0] MEM_RDATA,
  input  wire logic        MEM_ACK,
  input  wire logic        MEM_ABORT,
  output logic             LOCK,
  input  wire logic        CACHE_HIT,
  input  wire logic [31:0] CACHE_RDATA,
  input  wire logic        CACHE_UPDATEABLE,
  output logic             CACHE_WR,
  output logic             TRAP_ADDR_EXC,
  output logic             TRAP_DATA_ABORT
);

  initial begin
    if (NUM_REGS != 16) $error("xfer_swap_unit serves a 16-entry register list only");
  end

  function automatic reg_idx_t lowest_set(input logic [15:0] v);
    reg_idx_t r;
    r = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) r = i[3:0];
    end
    return r;
  endfunction : lowest_set

  function automatic logic [4:0] count_set(input logic [15:0] v);
    logic [4:0] c;
    c = 5'h00;
    for (int i = 0; i < 16; i++) begin
      c = c + {4'h0, v[i]};
    end
    return c;
  endfunction : count_set

  logic [31:0] rf [NUM_REGS];
  state_t      state_reg;
  logic [15:0] list_reg;
  reg_idx_t    base_reg;
  reg_idx_t    src_reg;
  reg_idx_t    dst_reg;
  logic        load_reg;
  logic        pre_reg;
  logic        up_reg;
  logic        wb_reg;
  logic        byte_reg;
  logic        swap_reg;
  logic        first_reg;
  logic        abort_reg;
  logic        exc_reg;
  logic [25:0] addr_reg;
  logic [31:0] swap_addr_reg;
  logic [31:0] wb_val_reg;
  logic [31:0] swap_rd_reg;
  logic        pend_v_reg;
  reg_idx_t    pend_idx_reg;
  logic [31:0] pend_data_reg;
  logic [7:0]  psw_reg;
  logic        cache_en_reg;
  logic        st_exc_reg;
  logic        st_abort_reg;
  logic        st_done_reg;
  logic        ack_reg;
  logic [31:0] rdat_reg;

  logic        wb_hit;
  logic        wb_wr;
  logic        busy;
  reg_idx_t    cur_idx;
  logic        from_cache;
  logic        step_done;
  logic [31:0] step_data;
  logic [4:0]  cnt;
  logic [31:0] base_val;
  logic [31:0] span;
  logic [31:0] lowest_addr;
  logic [31:0] swap_addr;
  logic        swap_exc;
  logic [31:0] rot_data;
  logic        finish_evt;
  logic        exc_evt;
  logic        abort_evt;

  assign wb_hit   = WB_CYC_I && WB_STB_I && !ack_reg;
  assign wb_wr    = wb_hit && WB_WE_I;
  assign busy     = (state_reg != ST_IDLE);
  assign cur_idx  = lowest_set(list_reg);
  assign from_cache = load_reg && cache_en_reg && CACHE_HIT && !exc_reg;
  assign step_done  = exc_reg || from_cache || MEM_ACK;
  assign step_data  = from_cache ? CACHE_RDATA : MEM_RDATA;

  // Setup arithmetic on the base held in the register file
  always_comb begin
    cnt      = count_set(WB_DAT_I[15:0]);
    base_val = rf[WB_DAT_I[`BC_BASE_LSB +: 4]];
    span     = {25'h0, cnt, 2'b00};
    if (WB_DAT_I[`BC_UP_BIT]) begin
      lowest_addr = WB_DAT_I[`BC_PRE_BIT] ? base_val + 32'h4 : base_val;
    end else begin
      lowest_addr = WB_DAT_I[`BC_PRE_BIT] ? base_val - span : base_val - span + 32'h4;
    end
  end

  // Exchange address; the counter register mixes the PSW mode bits into its low two bits
  always_comb begin
    swap_addr = rf[WB_DAT_I[`SC_BASE_LSB +: 4]];
    swap_exc  = |swap_addr[`ILLEGAL_HI:`ILLEGAL_LO];
    if (WB_DAT_I[`SC_BASE_LSB +: 4] == `COUNTER_IDX) begin
      swap_exc  = |psw_reg[7:2];
      swap_addr = {6'h00, rf[`COUNTER_IDX][25:2] + 24'h000002, psw_reg[1:0]};
    end
  end

  // Read lane handling for the exchange
  always_comb begin
    rot_data = MEM_RDATA >> {swap_addr_reg[1:0], 3'b000};
    rot_data = rot_data | (MEM_RDATA << {~swap_addr_reg[1:0] + 2'b01, 3'b000});
    if (swap_addr_reg[1:0] == 2'b00) rot_data = MEM_RDATA;
    if (byte_reg) rot_data = {24'h000000, rot_data[7:0]};
  end

  // Memory port; stores are never served from the cache so the manager sees every one not stopped by an address exception
  always_comb begin
    MEM_REQ   = 1'b0;
    MEM_WE    = 1'b0;
    MEM_ADDR  = 32'h0;
    MEM_WDATA = 32'h0;
    LOCK      = 1'b0;
    CACHE_WR  = 1'b0;
    if (state_reg == ST_XFER && list_reg != 16'h0) begin
      MEM_ADDR  = {6'h00, addr_reg[25:2], psw_reg[1:0]};
      MEM_REQ   = !exc_reg && !from_cache;
      MEM_WE    = !load_reg && !exc_reg;
      MEM_WDATA = rf[cur_idx];
      CACHE_WR  = !load_reg && !exc_reg && MEM_ACK && CACHE_UPDATEABLE && cache_en_reg;
    end
    if (state_reg == ST_SWRD || state_reg == ST_SWWR) begin
      LOCK     = 1'b1;
      MEM_REQ  = 1'b1;
      MEM_ADDR = swap_addr_reg;
    end
    if (state_reg == ST_SWWR) begin
      MEM_WE    = 1'b1;
      MEM_WDATA = byte_reg ? {4{rf[src_reg][7:0]}} : rf[src_reg];
      CACHE_WR  = MEM_ACK && CACHE_UPDATEABLE && cache_en_reg;
    end
  end

  // Sequencer
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (wb_wr && WB_ADR_I == `ADR_BLOCK_CMD) state_reg <= ST_SETUP;
          else if (wb_wr && WB_ADR_I == `ADR_SWAP_CMD) state_reg <= swap_exc ? ST_FINISH : ST_SWRD;
        end
        ST_SETUP: state_reg <= ST_XFER;
        ST_XFER: begin
          if (list_reg == 16'h0 || (step_done && (list_reg & (list_reg - 16'h1)) == 16'h0)) state_reg <= ST_FINISH;
        end
        ST_SWRD: if (MEM_ACK) state_reg <= ST_SWWR;
        ST_SWWR: if (MEM_ACK) state_reg <= ST_FINISH;
        ST_FINISH: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Command capture and transfer progress
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      list_reg      <= 16'h0;
      base_reg      <= 4'h0;
      src_reg       <= 4'h0;
      dst_reg       <= 4'h0;
      load_reg      <= 1'b0;
      pre_reg       <= 1'b0;
      up_reg        <= 1'b0;
      wb_reg        <= 1'b0;
      byte_reg      <= 1'b0;
      first_reg     <= 1'b0;
      abort_reg     <= 1'b0;
      exc_reg       <= 1'b0;
      addr_reg      <= 26'h0;
      swap_addr_reg <= 32'h0;
      wb_val_reg    <= 32'h0;
      swap_rd_reg   <= 32'h0;
    end else if (state_reg == ST_IDLE && wb_wr && WB_ADR_I == `ADR_BLOCK_CMD) begin
      list_reg   <= WB_DAT_I[`BC_LIST_LSB +: 16];
      base_reg   <= WB_DAT_I[`BC_BASE_LSB +: 4];
      load_reg   <= WB_DAT_I[`BC_LOAD_BIT];
      pre_reg    <= WB_DAT_I[`BC_PRE_BIT];
      up_reg     <= WB_DAT_I[`BC_UP_BIT];
      wb_reg     <= WB_DAT_I[`BC_WB_BIT] && WB_DAT_I[`BC_BASE_LSB +: 4] != `COUNTER_IDX;
      first_reg  <= 1'b1;
      abort_reg  <= 1'b0;
      exc_reg    <= |lowest_addr[`ILLEGAL_HI:`ILLEGAL_LO];
      addr_reg   <= lowest_addr[25:0];
      wb_val_reg <= WB_DAT_I[`BC_UP_BIT] ? base_val + span : base_val - span;
    end else if (state_reg == ST_IDLE && wb_wr && WB_ADR_I == `ADR_SWAP_CMD) begin
      list_reg      <= 16'h0;
      load_reg      <= 1'b0;
      wb_reg        <= 1'b0;
      src_reg       <= WB_DAT_I[`SC_SRC_LSB +: 4];
      dst_reg       <= WB_DAT_I[`SC_DST_LSB +: 4];
      byte_reg      <= WB_DAT_I[`SC_BYTE_BIT];
      swap_addr_reg <= swap_addr;
      exc_reg       <= swap_exc;
      abort_reg     <= 1'b0;
    end else if (state_reg == ST_XFER && list_reg != 16'h0 && step_done) begin
      list_reg  <= list_reg & ~(16'h1 << cur_idx);
      addr_reg  <= addr_reg + `WORD_BYTES;
      first_reg <= 1'b0;
      if (MEM_ACK && MEM_ABORT && !from_cache) abort_reg <= 1'b1;
    end else if ((state_reg == ST_SWRD || state_reg == ST_SWWR) && MEM_ACK) begin
      if (MEM_ABORT) abort_reg <= 1'b1;
      if (state_reg == ST_SWRD) swap_rd_reg <= rot_data;
    end
  end

  // Remembers which kind of command is in flight, for the finish step
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      swap_reg <= 1'b0;
    end else if (state_reg == ST_IDLE && wb_wr && WB_ADR_I == `ADR_BLOCK_CMD) begin
      swap_reg <= 1'b0;
    end else if (state_reg == ST_IDLE && wb_wr && WB_ADR_I == `ADR_SWAP_CMD) begin
      swap_reg <= 1'b1;
    end
  end

  // Register file: software port while idle, engine while busy
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      pend_v_reg    <= 1'b0;
      pend_idx_reg  <= 4'h0;
      pend_data_reg <= 32'h0;
    end else begin
      if (!busy && wb_wr && WB_ADR_I >= `ADR_REGFILE && WB_ADR_I <= `ADR_REGFILE_END) begin
        for (int b = 0; b < 4; b++) begin
          if (WB_SEL_I[b]) rf[WB_ADR_I[5:2]][8*b +: 8] <= WB_DAT_I[8*b +: 8];
        end
      end
      if (state_reg == ST_SETUP) pend_v_reg <= 1'b0;
      if (state_reg == ST_XFER && list_reg != 16'h0 && step_done) begin
        if (first_reg && wb_reg) rf[base_reg] <= wb_val_reg;
        if (load_reg) begin
          // One-deep delay so an abort can still cancel the previous load
          if (exc_reg || abort_reg || (MEM_ACK && MEM_ABORT && !from_cache)) begin
            pend_v_reg <= 1'b0;
          end else begin
            if (pend_v_reg) rf[pend_idx_reg] <= pend_data_reg;
            pend_v_reg    <= 1'b1;
            pend_idx_reg  <= cur_idx;
            pend_data_reg <= step_data;
          end
        end
      end
      if (state_reg == ST_FINISH) begin
        pend_v_reg <= 1'b0;
        if (load_reg && pend_v_reg && !abort_reg && !exc_reg) rf[pend_idx_reg] <= pend_data_reg;
        if (load_reg && wb_reg && (abort_reg || exc_reg)) rf[base_reg] <= wb_val_reg;
        if (swap_reg) begin
          // An aborted or trapped exchange leaves the destination untouched
          if (!abort_reg && !exc_reg) begin
            rf[dst_reg] <= swap_rd_reg;
          end
        end
      end
    end
  end

  assign finish_evt = (state_reg == ST_FINISH);
  assign exc_evt    = finish_evt && exc_reg;
  assign abort_evt  = finish_evt && abort_reg && !exc_reg;

  // Control and status; a trap event in the clearing cycle wins over the clear
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      psw_reg         <= `PSW_RESET;
      cache_en_reg    <= `CACHE_EN_RESET;
      st_exc_reg      <= 1'b0;
      st_abort_reg    <= 1'b0;
      st_done_reg     <= 1'b0;
      TRAP_ADDR_EXC   <= 1'b0;
      TRAP_DATA_ABORT <= 1'b0;
    end else begin
      if (wb_wr && WB_ADR_I == `ADR_PSW && WB_SEL_I[0]) psw_reg <= WB_DAT_I[7:0];
      if (wb_wr && WB_ADR_I == `ADR_CACHE_CTRL && WB_SEL_I[0]) cache_en_reg <= WB_DAT_I[0];
      if (wb_wr && WB_ADR_I == `ADR_STATUS && WB_SEL_I[0]) begin
        if (WB_DAT_I[`ST_ADDR_EXC_BIT]) st_exc_reg <= 1'b0;
        if (WB_DAT_I[`ST_ABORT_BIT]) st_abort_reg <= 1'b0;
        if (WB_DAT_I[`ST_DONE_BIT]) st_done_reg <= 1'b0;
      end
      if (exc_evt) st_exc_reg <= 1'b1;
      if (abort_evt) st_abort_reg <= 1'b1;
      if (finish_evt) st_done_reg <= 1'b1;
      TRAP_ADDR_EXC   <= exc_evt;
      TRAP_DATA_ABORT <= abort_evt;
    end
  end

  // Wishbone slave: one wait state, unmapped reads return zero, writes ignored
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h0;
    end else begin
      ack_reg  <= wb_hit;
      rdat_reg <= 32'h0;
      if (wb_hit && !WB_WE_I) begin
        if (WB_ADR_I == `ADR_STATUS) rdat_reg <= {28'h0, st_done_reg, st_abort_reg, st_exc_reg, busy};
        else if (WB_ADR_I == `ADR_PSW) rdat_reg <= {24'h0, psw_reg};
        else if (WB_ADR_I == `ADR_CACHE_CTRL) rdat_reg <= {31'h0, cache_en_reg};
        else if (WB_ADR_I >= `ADR_REGFILE && WB_ADR_I <= `ADR_REGFILE_END) rdat_reg <= rf[WB_ADR_I[5:2]];
      end
    end
  end

  assign WB_ACK_O = ack_reg;
  assign WB_DAT_O = rdat_reg;

endmodule : xfer_swap_unit

/* File: xfer_swap_assertions.sv */
// Port-level checks of the block transfer and exchange unit
`include "xfer_swap_defines.svh"
module xfer_swap_assertions (
  input wire logic        MCLK,
  input wire logic        SRST,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [7:0]  WB_ADR_I,
  input wire logic [3:0]  WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic        WB_ACK_O,
  input wire logic        MEM_REQ,
  input wire logic        MEM_WE,
  input wire logic [31:0] MEM_ADDR,
  input wire logic [31:0] MEM_WDATA,
  input wire logic        MEM_ACK,
  input wire logic        LOCK,
  input wire logic        CACHE_WR,
  input wire logic        TRAP_ADDR_EXC,
  input wire logic        TRAP_DATA_ABORT
);
  logic [1:0] mode_reg;
  // Shadow of the mode field, so the low address bits can be predicted
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      mode_reg <= 2'h3;
    end else if (WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O && WB_SEL_I[0] && WB_ADR_I == `ADR_PSW) begin
      mode_reg <= WB_DAT_I[1:0];
    end
  end
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (SRST);
  a_ack_next: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("register access not answered after one cycle");
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("register ack longer than one cycle");
  a_req_holds: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR) && $stable(MEM_WE) && $stable(MEM_WDATA))
    else $error("memory request changed before ack");
  a_addr_legal: assert property (MEM_REQ |-> MEM_ADDR[31:26] == 6'h00)
    else $error("memory request outside 26-bit space");
  a_mode_bits: assert property (MEM_REQ && !LOCK |-> MEM_ADDR[1:0] == mode_reg)
    else $error("block address low bits differ from mode");
  a_lock_read_first: assert property ($rose(LOCK) |-> MEM_REQ && !MEM_WE)
    else $error("locked pair does not start with a read");
  a_lock_pairs: assert property (LOCK && MEM_REQ && !MEM_WE && MEM_ACK |=> LOCK && MEM_REQ && MEM_WE)
    else $error("locked read not followed by locked write");
  a_lock_ends_write: assert property ($fell(LOCK) |-> $past(MEM_WE && MEM_ACK))
    else $error("lock dropped before the write completed");
  a_trap_pulse: assert property (TRAP_ADDR_EXC || TRAP_DATA_ABORT |=> !TRAP_ADDR_EXC && !TRAP_DATA_ABORT)
    else $error("trap pulse longer than one cycle");
  a_exc_quiet: assert property (TRAP_ADDR_EXC |-> !$past(MEM_REQ))
    else $error("memory request just before address trap");
  a_cache_wr_store: assert property (CACHE_WR |-> MEM_REQ && MEM_WE && MEM_ACK)
    else $error("cache written without a completed store");
endmodule : xfer_swap_assertions
bind xfer_swap_unit xfer_swap_assertions u_chk (.MCLK(MCLK), .SRST(SRST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_ACK_O(WB_ACK_O),
  .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_ACK(MEM_ACK), .LOCK(LOCK),
  .CACHE_WR(CACHE_WR),
  .TRAP_ADDR_EXC(TRAP_ADDR_EXC), .TRAP_DATA_ABORT(TRAP_DATA_ABORT));

/* File: mem_model.sv */
// Memory manager and memory: word store with wait states and abort injection
module mem_model (
  input  wire logic        MCLK,
  input  wire logic        MEM_REQ,
  input  wire logic        MEM_WE,
  input  wire logic [31:0] MEM_ADDR,
  input  wire logic [31:0] MEM_WDATA,
  output logic      [31:0] MEM_RDATA,
  output logic             MEM_ACK,
  output logic             MEM_ABORT,
  input  wire logic [1:0]  wait_cycles,
  input  wire logic [13:0] abort_addr
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] mem [0:4095];
  logic [31:0] last_wdata;
  logic [1:0]  cnt = 2'h0;
  logic        hit_abort;
  int          writes = 0;
  assign hit_abort = abort_addr != 14'h0 && MEM_ADDR[13:2] == abort_addr[13:2];
  always @(posedge MCLK) begin
    if (MEM_REQ && !MEM_ACK && cnt == wait_cycles) begin
      MEM_ACK <= 1'b1; // Sole master: ownership is never taken away, locked or not
      MEM_ABORT <= hit_abort;
      MEM_RDATA <= mem[MEM_ADDR[13:2]];
      cnt <= 2'h0;
      if (MEM_WE && !hit_abort) begin // Aborted stores never reach memory
        mem[MEM_ADDR[13:2]] <= MEM_WDATA;
        writes <= writes + 1;
      end
      if (MEM_WE) begin
        last_wdata <= MEM_WDATA;
      end
    end else begin
      MEM_ACK <= 1'b0;
      MEM_ABORT <= 1'b0;
      MEM_RDATA <= ~MEM_RDATA; // Released bus keeps no stale data
      cnt <= (MEM_REQ && !MEM_ACK) ? cnt + 2'h1 : 2'h0;
    end
  end
endmodule : mem_model

/* File: block_transfer_and_swap_unit_test.sv */
// Self-checking bench for the block transfer and exchange unit
`include "xfer_swap_defines.svh"
module block_transfer_and_swap_unit_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic MCLK = 1'b0, SRST = 1'b1, WB_CYC_I = 1'b0, WB_STB_I = 1'b0, WB_WE_I = 1'b0, CACHE_HIT = 1'b0, CACHE_UPDATEABLE = 1'b0;
  logic [7:0]  WB_ADR_I = 8'h00;
  logic [31:0] WB_DAT_I = 32'h0, rdata, a;
  logic [13:0] abort_addr = 14'h0;
  logic [1:0]  wait_cycles = 2'h0;
  wire logic [31:0] WB_DAT_O, MEM_ADDR, MEM_WDATA, MEM_RDATA;
  wire logic WB_ACK_O, MEM_REQ, MEM_WE, MEM_ACK, MEM_ABORT, LOCK, TRAP_ADDR_EXC, TRAP_DATA_ABORT;
  int fail_count = 0, n_compared = 0, w;
  always #12.5 MCLK = ~MCLK;
  xfer_swap_unit u_dut (.MCLK(MCLK), .SRST(SRST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
    .WB_ADR_I(WB_ADR_I), .WB_SEL_I(4'hf), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA),
    .MEM_ACK(MEM_ACK), .MEM_ABORT(MEM_ABORT), .LOCK(LOCK), .CACHE_HIT(CACHE_HIT), .CACHE_RDATA(32'h77),
    .CACHE_UPDATEABLE(CACHE_UPDATEABLE), .CACHE_WR(), .TRAP_ADDR_EXC(TRAP_ADDR_EXC), .TRAP_DATA_ABORT(TRAP_DATA_ABORT));
  mem_model u_mem (.MCLK(MCLK), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
    .MEM_RDATA(MEM_RDATA), .MEM_ACK(MEM_ACK), .MEM_ABORT(MEM_ABORT), .wait_cycles(wait_cycles), .abort_addr(abort_addr));
  task automatic results();
    if (fail_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results
  // Entered just after a rising edge; leaves one idle cycle behind it
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
    int n;
    n = 0;
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= we;
    WB_ADR_I <= adr;
    WB_DAT_I <= d;
    @(posedge MCLK);
    while (WB_ACK_O !== 1'b1 && n < 50) begin
      @(posedge MCLK);
      n++;
    end
    rdata = WB_DAT_O;
    fail_count += (n == 50);
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    @(posedge MCLK);
  endtask : wb
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask : check
  task automatic set_reg(input int n, input logic [31:0] v);
    wb(1'b1, `ADR_REGFILE + 8'(4 * n), v);
  endtask : set_reg
  task automatic reg_is(input int n, input logic [31:0] exp);
    wb(1'b0, `ADR_REGFILE + 8'(4 * n), 32'h0);
    check($sformatf("r%0d", n), exp, rdata);
  endtask : reg_is
  // Clears sticky flags, starts a command and polls busy; rdata keeps the final status
  task automatic run(input logic [7:0] adr, input logic [31:0] c);
    int n;
    n = 0;
    wb(1'b1, `ADR_STATUS, 32'he);
    wb(1'b1, adr, c);
    do begin
      wb(1'b0, `ADR_STATUS, 32'h0);
      n++;
    end while (rdata[`ST_BUSY_BIT] !== 1'b0 && n < 100);
    fail_count += (n == 100);
  endtask : run
  function automatic logic [31:0] blk(input logic [15:0] l, input logic [3:0] b, input logic ld, pre, up, wbk);
    return {wbk, up, pre, ld, 8'h00, b, l};
  endfunction : blk
  function automatic logic [31:0] xch(input logic [3:0] b, s, d, input logic byt);
    return {19'h0, byt, d, s, b};
  endfunction : xch
  initial begin
    #750000;
    fail_count++;
    results();
  end
  initial begin
    u_mem.mem[12'hc00] = 32'h5a000000;
    u_mem.mem[12'hc01] = 32'h5a000001;
    u_mem.mem[12'hc40] = 32'h0bad0bad;
    u_mem.mem[12'h800] = 32'h66666666;
    u_mem.mem[12'h801] = 32'h88888888;
    u_mem.mem[12'h480] = 32'h01020304;
    u_mem.mem[12'h481] = 32'haabbccdd;
    u_mem.mem[12'h482] = 32'h44332211;
    repeat (16) @(posedge MCLK);
    SRST <= 1'b0;
    @(posedge MCLK);
    wb(1'b0, `ADR_PSW, 32'h0);
    check("psw", 32'h3, rdata);
    wb(1'b0, 8'h20, 32'h0);
    check("unmapped", 32'h0, rdata);
    set_reg(0, 32'h1000);
    set_reg(1, 32'h11);
    set_reg(7, 32'h77);
    run(`ADR_BLOCK_CMD, blk(16'h00a3, 4'h0, 1'b0, 1'b0, 1'b1, 1'b1));
    check("m0", 32'h1000, u_mem.mem[12'h400]);
    check("m7", 32'h77, u_mem.mem[12'h403]);
    reg_is(0, 32'h1010);
    set_reg(4, 32'h1100);
    run(`ADR_BLOCK_CMD, blk(16'h0012, 4'h4, 1'b0, 1'b0, 1'b1, 1'b1));
    check("m4", 32'h1108, u_mem.mem[12'h441]);
    set_reg(14, 32'h1800);
    for (int m = 0; m < 8; m++) begin
      a = m[1] ? (m[0] ? 32'h1804 : 32'h17fc) : 32'h1800;
      u_mem.mem[a[13:2]] = 32'hbeef0000 | m;
      set_reg(9, 32'hc0de0000 | m);
      run(`ADR_BLOCK_CMD, blk(16'h0200, 4'he, m[2], m[1], m[0], 1'b0));
      wb(1'b0, `ADR_REGFILE + 8'h24, 32'h0);
      check("mode", m[2] ? 32'hbeef0000 | m : 32'hc0de0000 | m, m[2] ? rdata : u_mem.mem[a[13:2]]);
    end
    set_reg(6, 32'h2008);
    run(`ADR_BLOCK_CMD, blk(16'h0140, 4'h6, 1'b1, 1'b1, 1'b0, 1'b1));
    reg_is(6, 32'h66666666);
    reg_is(8, 32'h88888888);
    set_reg(2, 32'hdead0002);
    set_reg(10, 32'h3000);
    abort_addr <= 14'h300c;
    run(`ADR_BLOCK_CMD, blk(16'h000f, 4'ha, 1'b1, 1'b0, 1'b1, 1'b1));
    check("abort", 32'h1, 32'(rdata[`ST_ABORT_BIT]));
    reg_is(1, 32'h5a000001);
    reg_is(2, 32'hdead0002);
    reg_is(10, 32'h3010);
    set_reg(11, 32'h3100);
    set_reg(1, 32'h12345678);
    abort_addr <= 14'h3100;
    run(`ADR_BLOCK_CMD, blk(16'h0003, 4'hb, 1'b0, 1'b0, 1'b1, 1'b1));
    abort_addr <= 14'h0;
    check("abort", 32'h1, 32'(rdata[`ST_ABORT_BIT]));
    check("m1", 32'h12345678, u_mem.mem[12'hc41]);
    reg_is(11, 32'h3108);
    w = u_mem.writes;
    set_reg(12, 32'h04000000);
    run(`ADR_BLOCK_CMD, blk(16'h0001, 4'hc, 1'b0, 1'b0, 1'b1, 1'b0));
    check("exc", 32'h1, 32'(rdata[`ST_ADDR_EXC_BIT]));
    check("writes", 32'(w), 32'(u_mem.writes));
    wb(1'b1, `ADR_CACHE_CTRL, 32'h1);
    CACHE_HIT <= 1'b1;
    CACHE_UPDATEABLE <= 1'b1;
    set_reg(13, 32'h3200);
    run(`ADR_BLOCK_CMD, blk(16'h0020, 4'hd, 1'b1, 1'b0, 1'b1, 1'b0));
    reg_is(5, 32'h77);
    set_reg(1, 32'h1200);
    set_reg(2, 32'hcafef00d);
    wait_cycles <= 2'h2;
    run(`ADR_SWAP_CMD, xch(4'h1, 4'h2, 4'h3, 1'b0));
    reg_is(3, 32'h01020304);
    check("swap", 32'hcafef00d, u_mem.mem[12'h480]);
    CACHE_HIT <= 1'b0;
    set_reg(1, 32'h1205);
    set_reg(2, 32'h5a);
    run(`ADR_SWAP_CMD, xch(4'h1, 4'h2, 4'h3, 1'b1));
    reg_is(3, 32'hcc);
    check("byte out", 32'h5a5a5a5a, u_mem.last_wdata);
    set_reg(1, 32'h1209);
    set_reg(2, 32'h87654321);
    run(`ADR_SWAP_CMD, xch(4'h1, 4'h2, 4'h2, 1'b0));
    reg_is(2, 32'h11443322);
    check("word out", 32'h87654321, u_mem.last_wdata);
    set_reg(15, 32'h1240);
    set_reg(2, 32'h600d);
    run(`ADR_SWAP_CMD, xch(4'hf, 4'h2, 4'h3, 1'b0));
    check("pc swap", 32'h600d, u_mem.mem[12'h492]);
    wb(1'b1, `ADR_PSW, 32'h13);
    run(`ADR_SWAP_CMD, xch(4'hf, 4'h2, 4'h3, 1'b0));
    check("exc", 32'h1, 32'(rdata[`ST_ADDR_EXC_BIT]));
    wb(1'b1, `ADR_PSW, 32'h03);
    w = u_mem.writes;
    set_reg(1, 32'h08000000);
    run(`ADR_SWAP_CMD, xch(4'h1, 4'h2, 4'h3, 1'b0));
    check("exc", 32'h1, 32'(rdata[`ST_ADDR_EXC_BIT]));
    check("writes", 32'(w), 32'(u_mem.writes));
    results();
  end
endmodule : block_transfer_and_swap_unit_test
